// *** verilog/apc_cfg.svh ***
// constants for the axis position, compare and latch block
`ifndef APC_CFG_SVH
`define APC_CFG_SVH

// clock and timing
`define APC_CLK_PERIOD_NS   100
`define APC_CMP_PULSE_NS    33000
`define APC_CMP_PULSE_CYC   (`APC_CMP_PULSE_NS / `APC_CLK_PERIOD_NS)

// widths and depths
`define APC_POS_W           28
`define APC_PER_W           16
`define APC_BL_W            16
`define APC_FIFO_DEPTH      16
`define APC_ADDR_W          8
`define APC_MIN_PERIOD      16'h0002

// register byte offsets
`define APC_REG_CTRL        8'h00
`define APC_REG_CMD         8'h04
`define APC_REG_MOVE        8'h08
`define APC_REG_PERIOD      8'h0c
`define APC_REG_BACKLASH    8'h10
`define APC_REG_POSITION    8'h14
`define APC_REG_LATCH       8'h18
`define APC_REG_CMP         8'h1c
`define APC_REG_STATUS      8'h20
`define APC_REG_INT_STATUS  8'h24
`define APC_REG_INT_MASK    8'h28

// control bits
`define APC_CTRL_DUAL       0
`define APC_CTRL_INTERP     1
`define APC_CTRL_STOP_ABN   2
`define APC_CTRL_SYNC       3
`define APC_CTRL_IDX_CLR    4
`define APC_CTRL_W          5

// command bits
`define APC_CMD_START       0
`define APC_CMD_STOP        1

// move register: direction bit above the step count
`define APC_MOVE_DIR        31

// status bits
`define APC_ST_BUSY         0
`define APC_ST_ARMED        1
`define APC_ST_FULL         2
`define APC_ST_EMPTY        3
`define APC_ST_DIR          4
`define APC_ST_LEVEL_LSB    8

// interrupt bits
`define APC_INT_CMP         0
`define APC_INT_LATCH       1
`define APC_INT_DONE        2
`define APC_INT_EMPTY       3
`define APC_INT_ABN         4
`define APC_INT_W           5

// reset values
`define APC_CTRL_RST        5'h00
`define APC_PERIOD_RST      16'h0064
`define APC_BACKLASH_RST    16'h0000
`define APC_MASK_RST        5'h00

`endif

// *** verilog/apc_pkg.sv ***
// types shared by the axis position, compare and latch block
package apc_pkg;

	typedef enum logic [1:0] {
		APC_IDLE,
		APC_CORRECT,
		APC_MOVE
	} apc_step_state_e;

endpackage

// *** verilog/apc_step_gen.sv ***
// step pulse generator with backlash correction ahead of a reversed move
`timescale 1ns/1ps
`include "apc_cfg.svh"

module apc_step_gen #(
	parameter int POS_W = `APC_POS_W,
	parameter int PER_W = `APC_PER_W,
	parameter int BL_W  = `APC_BL_W
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_b,
	// commands
	input  wire logic             start,
	input  wire logic             stop,
	input  wire logic             dir,
	input  wire logic [POS_W-1:0] steps,
	input  wire logic [PER_W-1:0] period,
	input  wire logic [BL_W-1:0]  backlash,
	input  wire logic             backlash_en,
	input  wire logic             dual_pulse_format,
	// drive lines and state
	output logic                  pulse_a,
	output logic                  pulse_b,
	output logic                  busy,
	output logic                  done,
	output logic                  cur_dir
);

	apc_pkg::apc_step_state_e st, next_st;
	logic [POS_W-1:0] remain, next_remain, hold, next_hold;
	logic [PER_W-1:0] timer, next_timer, per_eff, half;
	logic             last_dir, next_last_dir, next_cur_dir, next_done, active;
	logic             next_pulse_a, next_pulse_b, next_busy, step_end;

	always_comb begin
		// one cycle high and one low is the fastest a single clock can toggle
		per_eff = (period < `APC_MIN_PERIOD) ? `APC_MIN_PERIOD : period;
		half = per_eff >> 1;
		step_end = (timer == per_eff - 1'b1);
		next_st = st;
		next_remain = remain;
		next_hold = hold;
		next_timer = timer;
		next_last_dir = last_dir;
		next_cur_dir = cur_dir;
		next_done = 1'b0;
		case (st)
			apc_pkg::APC_IDLE: begin
				next_timer = '0;
				if (start && steps != '0) begin
					next_cur_dir = dir;
					next_last_dir = dir;
					next_hold = steps;
					// reversal with correction enabled goes through the slack first
					if (backlash_en && dir != last_dir && backlash != '0) begin
						next_st = apc_pkg::APC_CORRECT;
						next_remain = POS_W'(backlash);
					end else begin
						next_st = apc_pkg::APC_MOVE;
						next_remain = steps;
					end
				end else if (start) begin
					next_done = 1'b1;
				end
			end
			apc_pkg::APC_CORRECT, apc_pkg::APC_MOVE: begin
				next_timer = step_end ? '0 : timer + 1'b1;
				if (step_end) begin
					next_remain = remain - 1'b1;
					if (remain == POS_W'(1)) begin
						if (st == apc_pkg::APC_CORRECT) begin
							next_st = apc_pkg::APC_MOVE;
							next_remain = hold;
						end else begin
							next_st = apc_pkg::APC_IDLE;
							next_done = 1'b1;
						end
					end
				end
			end
			default: begin
				next_st = apc_pkg::APC_IDLE;
			end
		endcase
		if (stop && st != apc_pkg::APC_IDLE) begin
			next_st = apc_pkg::APC_IDLE;
			next_timer = '0;
			next_done = 1'b1;
		end
		active = (next_st != apc_pkg::APC_IDLE) && (next_timer < half);
		next_busy = (next_st != apc_pkg::APC_IDLE);
		if (dual_pulse_format) begin
			next_pulse_a = active && !next_cur_dir;
			next_pulse_b = active && next_cur_dir;
		end else begin
			next_pulse_a = active;
			next_pulse_b = next_cur_dir;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st <= apc_pkg::APC_IDLE;
			remain <= '0;
			hold <= '0;
			timer <= '0;
			last_dir <= 1'b0;
			cur_dir <= 1'b0;
			done <= 1'b0;
			busy <= 1'b0;
			pulse_a <= 1'b0;
			pulse_b <= 1'b0;
		end else begin
			st <= next_st;
			remain <= next_remain;
			hold <= next_hold;
			timer <= next_timer;
			last_dir <= next_last_dir;
			cur_dir <= next_cur_dir;
			done <= next_done;
			busy <= next_busy;
			pulse_a <= next_pulse_a;
			pulse_b <= next_pulse_b;
		end
	end

endmodule

// *** verilog/apc_axis.sv ***
// one motion axis: encoder counter, compare fifo and trigger, latch, step output, apb
`timescale 1ns/1ps
`include "apc_cfg.svh"

module apc_axis #(
	parameter int POS_W  = `APC_POS_W,
	parameter int DEPTH  = `APC_FIFO_DEPTH,
	parameter int PULSE  = `APC_CMP_PULSE_CYC
) (
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   rst_b,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`APC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// encoder, latch and alarm
	input  wire logic                   encoder_phase_a,
	input  wire logic                   encoder_phase_b,
	input  wire logic                   encoder_index_in,
	input  wire logic                   position_capture_in,
	input  wire logic                   axis_alarm_in,
	// sync lines
	input  wire logic                   sync_start_line,
	input  wire logic                   sync_stop_line,
	output logic                        sync_start_drive,
	output logic                        sync_stop_drive,
	// drive and trigger outputs
	output logic                        step_out_a,
	output logic                        step_out_b,
	output logic                        compare_trigger_out,
	output logic                        irq
);

	localparam int LVL_W = $clog2(DEPTH + 1);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(PULSE + 1);

	if (POS_W < 8 || POS_W > 30 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || PULSE < 1) begin
		$error("apc_axis: unsupported parameter values");
	end

	function automatic logic [31:0] sext(input logic [POS_W-1:0] v);
		sext = {{(32 - POS_W){v[POS_W-1]}}, v};
	endfunction

	// apb and register state
	logic [`APC_CTRL_W-1:0] ctrl, next_ctrl;
	logic [`APC_PER_W-1:0]  period, next_period;
	logic [`APC_BL_W-1:0]   backlash, next_backlash;
	logic [POS_W-1:0]       move_steps, next_move_steps;
	logic                   move_dir, next_move_dir;
	logic [`APC_INT_W-1:0]  int_status, next_int_status, int_mask, next_int_mask, ev;
	logic [31:0]            next_prdata, rd;
	logic                   next_pready, next_pslverr, next_irq, hit, wr, wr_err;
	// counter, compare and latch state
	logic [POS_W-1:0]       pos, next_pos, latch_val, next_latch_val, cmp_val, next_cmp_val;
	logic [1:0]             quad_prev, next_quad_prev;
	logic                   cap_prev, next_cap_prev, idx_prev, next_idx_prev;
	logic                   armed, next_armed, match;
	logic [CNT_W-1:0]       pulse_cnt, next_pulse_cnt;
	logic                   next_trigger;
	logic [POS_W-1:0]       fifo_mem [DEPTH];
	logic [PTR_W-1:0]       wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [LVL_W-1:0]       level, next_level;
	logic                   push, pop;
	// motion and sync state
	logic                   sync_start_prev, next_sync_start_prev, sync_stop_prev;
	logic                   next_sync_stop_prev, alarm_prev, next_alarm_prev;
	logic                   go_start, go_stop, abn_stop, next_start_drive, next_stop_drive;
	logic                   sg_busy, sg_done, sg_dir;

	// register bus: zero-wait setup, one wait state, then the answer
	always_comb begin
		hit = 1'b1;
		rd = 32'h0000_0000;
		case (paddr)
			`APC_REG_CTRL:       rd[`APC_CTRL_W-1:0] = ctrl;
			`APC_REG_CMD:        rd = 32'h0000_0000;
			`APC_REG_MOVE:       rd = {move_dir, (31 - POS_W)'(0), move_steps};
			`APC_REG_PERIOD:     rd[`APC_PER_W-1:0] = period;
			`APC_REG_BACKLASH:   rd[`APC_BL_W-1:0] = backlash;
			`APC_REG_POSITION:   rd = sext(pos);
			`APC_REG_LATCH:      rd = sext(latch_val);
			`APC_REG_CMP:        rd = sext(cmp_val);
			`APC_REG_STATUS: begin
				rd[`APC_ST_BUSY] = sg_busy;
				rd[`APC_ST_ARMED] = armed;
				rd[`APC_ST_FULL] = (level == LVL_W'(DEPTH));
				rd[`APC_ST_EMPTY] = (level == '0);
				rd[`APC_ST_DIR] = sg_dir;
				rd[`APC_ST_LEVEL_LSB +: LVL_W] = level;
			end
			`APC_REG_INT_STATUS: rd[`APC_INT_W-1:0] = int_status;
			`APC_REG_INT_MASK:   rd[`APC_INT_W-1:0] = int_mask;
			default:             hit = 1'b0;
		endcase
		next_pready = psel && penable && !pready;
		next_prdata = next_pready ? rd : 32'h0000_0000;
		// a push into a full fifo is dropped and flagged as an error
		next_pslverr = next_pready && (!hit || (pwrite && paddr == `APC_REG_CMP &&
			level == LVL_W'(DEPTH)));
		wr = psel && penable && pready && pwrite;
		wr_err = wr && pslverr;
	end

	always_comb begin
		next_ctrl = ctrl;
		next_period = period;
		next_backlash = backlash;
		next_move_steps = move_steps;
		next_move_dir = move_dir;
		next_int_mask = int_mask;
		if (wr && !wr_err) begin
			case (paddr)
				`APC_REG_CTRL:     next_ctrl = pwdata[`APC_CTRL_W-1:0];
				`APC_REG_PERIOD:   next_period = pwdata[`APC_PER_W-1:0];
				`APC_REG_BACKLASH: next_backlash = pwdata[`APC_BL_W-1:0];
				`APC_REG_INT_MASK: next_int_mask = pwdata[`APC_INT_W-1:0];
				`APC_REG_MOVE: begin
					next_move_steps = pwdata[POS_W-1:0];
					next_move_dir = pwdata[`APC_MOVE_DIR];
				end
				default: begin
				end
			endcase
		end
		// hardware set wins over a write-one clear in the same cycle
		next_int_status = int_status;
		if (wr && paddr == `APC_REG_INT_STATUS) begin
			next_int_status = int_status & ~pwdata[`APC_INT_W-1:0];
		end
		next_int_status = next_int_status | ev;
		next_irq = |(next_int_status & next_int_mask);
	end

	// quadrature decode and position counter
	always_comb begin
		next_quad_prev = {encoder_phase_a, encoder_phase_b};
		next_idx_prev = encoder_index_in;
		next_pos = pos;
		// b leading: 00 01 11 10 counts up; a leading runs the cycle backwards
		case ({quad_prev, encoder_phase_a, encoder_phase_b})
			4'b0001, 4'b0111, 4'b1110, 4'b1000: next_pos = pos + 1'b1;
			4'b0010, 4'b1011, 4'b1101, 4'b0100: next_pos = pos - 1'b1;
			default: next_pos = pos;
		endcase
		if (ctrl[`APC_CTRL_IDX_CLR] && encoder_index_in && !idx_prev) begin
			next_pos = '0;
		end
		if (wr && !wr_err && paddr == `APC_REG_POSITION) begin
			next_pos = pwdata[POS_W-1:0];
		end
	end

	// latch capture on the rising edge of the capture input
	always_comb begin
		next_cap_prev = position_capture_in;
		next_latch_val = latch_val;
		if (position_capture_in && !cap_prev) begin
			next_latch_val = pos;
		end
	end

	// compare fifo, reload and trigger pulse; reload takes one cycle, far below 33 us
	always_comb begin
		push = wr && !wr_err && paddr == `APC_REG_CMP;
		match = armed && pos == cmp_val;
		pop = !armed && level != '0;
		next_armed = armed;
		next_cmp_val = cmp_val;
		if (match) begin
			next_armed = 1'b0;
		end else if (pop) begin
			next_armed = 1'b1;
			next_cmp_val = fifo_mem[rd_ptr];
		end
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = (pop && !match) ? rd_ptr + 1'b1 : rd_ptr;
		next_level = LVL_W'(level + LVL_W'(push) - LVL_W'(pop && !match));
		next_pulse_cnt = pulse_cnt;
		if (match) begin
			next_pulse_cnt = CNT_W'(PULSE);
		end else if (pulse_cnt != '0) begin
			next_pulse_cnt = pulse_cnt - 1'b1;
		end
		next_trigger = (next_pulse_cnt != '0);
	end

	// start and stop, local or through the shared sync lines
	always_comb begin
		next_sync_start_prev = sync_start_line;
		next_sync_stop_prev = sync_stop_line;
		next_alarm_prev = axis_alarm_in;
		abn_stop = axis_alarm_in && !alarm_prev;
		go_start = (wr && paddr == `APC_REG_CMD && pwdata[`APC_CMD_START]) ||
			(ctrl[`APC_CTRL_SYNC] && sync_start_line && !sync_start_prev);
		go_stop = (wr && paddr == `APC_REG_CMD && pwdata[`APC_CMD_STOP]) || abn_stop ||
			(ctrl[`APC_CTRL_SYNC] && sync_stop_line && !sync_stop_prev);
		next_start_drive = ctrl[`APC_CTRL_SYNC] && wr && paddr == `APC_REG_CMD &&
			pwdata[`APC_CMD_START];
		next_stop_drive = ctrl[`APC_CTRL_SYNC] && ((wr && paddr == `APC_REG_CMD &&
			pwdata[`APC_CMD_STOP]) || (ctrl[`APC_CTRL_STOP_ABN] && abn_stop));
		ev = '0;
		ev[`APC_INT_CMP] = match;
		ev[`APC_INT_LATCH] = position_capture_in && !cap_prev;
		ev[`APC_INT_DONE] = sg_done;
		ev[`APC_INT_EMPTY] = match && level == '0;
		ev[`APC_INT_ABN] = abn_stop;
	end

	always_ff @(posedge mclk) begin
		if (push) begin
			fifo_mem[wr_ptr] <= pwdata[POS_W-1:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= `APC_CTRL_RST;
			period <= `APC_PERIOD_RST;
			backlash <= `APC_BACKLASH_RST;
			move_steps <= '0;
			move_dir <= 1'b0;
			int_status <= '0;
			int_mask <= `APC_MASK_RST;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
			pos <= '0;
			quad_prev <= 2'h0;
			idx_prev <= 1'b0;
			cap_prev <= 1'b0;
			latch_val <= '0;
			armed <= 1'b0;
			cmp_val <= '0;
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
			pulse_cnt <= '0;
			compare_trigger_out <= 1'b0;
			sync_start_prev <= 1'b0;
			sync_stop_prev <= 1'b0;
			alarm_prev <= 1'b0;
			sync_start_drive <= 1'b0;
			sync_stop_drive <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			period <= next_period;
			backlash <= next_backlash;
			move_steps <= next_move_steps;
			move_dir <= next_move_dir;
			int_status <= next_int_status;
			int_mask <= next_int_mask;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			irq <= next_irq;
			pos <= next_pos;
			quad_prev <= next_quad_prev;
			idx_prev <= next_idx_prev;
			cap_prev <= next_cap_prev;
			latch_val <= next_latch_val;
			armed <= next_armed;
			cmp_val <= next_cmp_val;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			level <= next_level;
			pulse_cnt <= next_pulse_cnt;
			compare_trigger_out <= next_trigger;
			sync_start_prev <= next_sync_start_prev;
			sync_stop_prev <= next_sync_stop_prev;
			alarm_prev <= next_alarm_prev;
			sync_start_drive <= next_start_drive;
			sync_stop_drive <= next_stop_drive;
		end
	end

	apc_step_gen #(
		.POS_W (POS_W),
		.PER_W (`APC_PER_W),
		.BL_W  (`APC_BL_W)
	) u_step (
		.mclk              (mclk),
		.rst_b             (rst_b),
		.start             (go_start),
		.stop              (go_stop),
		.dir               (move_dir),
		.steps             (move_steps),
		.period            (period),
		.backlash          (backlash),
		.backlash_en       (!ctrl[`APC_CTRL_INTERP]),
		.dual_pulse_format (ctrl[`APC_CTRL_DUAL]),
		.pulse_a           (step_out_a),
		.pulse_b           (step_out_b),
		.busy              (sg_busy),
		.done              (sg_done),
		.cur_dir           (sg_dir)
	);

endmodule

// *** verification/apc_axis_chk.sv ***
// assertion checker for the axis block, bound to its ports
`timescale 1ns/1ps
`include "apc_cfg.svh"
module apc_axis_chk #(
	parameter int PULSE = `APC_CMP_PULSE_CYC
) (
	// clock and reset
	input wire logic                   mclk,
	input wire logic                   rst_b,
	// apb
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic                   pready,
	input wire logic [`APC_ADDR_W-1:0] paddr,
	input wire logic [31:0]            pwdata,
	// pins
	input wire logic                   axis_alarm_in,
	input wire logic                   position_capture_in,
	input wire logic                   sync_start_drive,
	input wire logic                   sync_stop_drive,
	input wire logic                   step_out_a,
	input wire logic                   step_out_b,
	input wire logic                   compare_trigger_out,
	input wire logic                   irq
);
	logic [4:0]  ctrl, next_ctrl, mask, next_mask;
	logic [15:0] hi_cnt, next_hi_cnt;
	logic        wr;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	// shadow words follow completed writes, so mode-dependent checks need no port
	assign wr = psel && penable && pready && pwrite;
	always_comb begin
		next_ctrl = (wr && paddr == `APC_REG_CTRL) ? pwdata[4:0] : ctrl;
		next_mask = (wr && paddr == `APC_REG_INT_MASK) ? pwdata[4:0] : mask;
		next_hi_cnt = compare_trigger_out ? hi_cnt + 16'h1 : 16'h0;
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= 5'h00;
			mask <= 5'h00;
			hi_cnt <= 16'h0;
		end else begin
			ctrl <= next_ctrl;
			mask <= next_mask;
			hi_cnt <= next_hi_cnt;
		end
	end
	AST_TRIG_WIDTH: assert property ($fell(compare_trigger_out) |-> hi_cnt == 16'(PULSE))
		else $error("trigger pulse width wrong");
	AST_CMP_IRQ: assert property ($rose(compare_trigger_out) && mask[0] |-> ##[0:2] irq)
		else $error("compare event raised no irq");
	AST_LTC_IRQ: assert property ($rose(position_capture_in) && mask[1] |-> ##[1:3] irq)
		else $error("capture raised no irq");
	AST_STA_ONE: assert property (sync_start_drive |=> !sync_start_drive)
		else $error("sync start drive longer than one cycle");
	AST_STP_ONE: assert property (sync_stop_drive |=> !sync_stop_drive)
		else $error("sync stop drive longer than one cycle");
	AST_ABN_SYNC: assert property ($rose(axis_alarm_in) && ctrl[2] && ctrl[3] |-> ##[1:3] sync_stop_drive)
		else $error("abnormal stop did not drive sync stop");
	AST_ALM_HALT: assert property ($rose(axis_alarm_in) |->
		##3 (!step_out_a && !(ctrl[0] && step_out_b))[*8])
		else $error("steps continue after alarm");
	AST_DUAL_EXCL: assert property (ctrl[0] |-> !(step_out_a && step_out_b))
		else $error("cw and ccw pulses together");
	AST_DIR_HOLD: assert property (!ctrl[0] && step_out_a && $past(step_out_a) |-> $stable(step_out_b))
		else $error("direction changed during a pulse");
endmodule

bind apc_axis apc_axis_chk #(.PULSE(PULSE)) u_chk (.mclk(mclk), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
	.axis_alarm_in(axis_alarm_in), .position_capture_in(position_capture_in),
	.sync_start_drive(sync_start_drive), .sync_stop_drive(sync_stop_drive),
	.step_out_a(step_out_a), .step_out_b(step_out_b),
	.compare_trigger_out(compare_trigger_out), .irq(irq));

// *** verification/apc_far_model.sv ***
// encoder and step-counting drive facing one axis
`timescale 1ns/1ps
module apc_far_model (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst_b,
	// bench requests
	input  wire logic enc_up,
	input  wire logic enc_dn,
	input  wire logic dual,
	// axis pins
	input  wire logic step_out_a,
	input  wire logic step_out_b,
	output logic      encoder_phase_a,
	output logic      encoder_phase_b,
	// step tallies
	output int        fwd_cnt,
	output int        rev_cnt
);
	logic [1:0] gray;
	logic       a_q, b_q;
	// one phase change per cycle, never both lines at once
	assign encoder_phase_a = gray[1];
	assign encoder_phase_b = gray[0];
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			gray <= 2'h0;
			a_q <= 1'b0;
			b_q <= 1'b0;
			fwd_cnt <= 0;
			rev_cnt <= 0;
		end else begin
			if (enc_up)
				gray <= {gray[0], ~gray[1]};
			else if (enc_dn)
				gray <= {~gray[0], gray[1]};
			a_q <= step_out_a;
			b_q <= step_out_b;
			// direction level is read at the pulse edge in pulse/dir format
			if (step_out_a && !a_q) begin
				if (dual || !step_out_b)
					fwd_cnt <= fwd_cnt + 1;
				else
					rev_cnt <= rev_cnt + 1;
			end
			if (dual && step_out_b && !b_q)
				rev_cnt <= rev_cnt + 1;
		end
	end
endmodule

// *** verification/tb_apc_axis.sv ***
// self-checking bench for one axis
`timescale 1ns/1ps
`include "apc_cfg.svh"
module tb_apc_axis;
	localparam int PULSE = 5;
	logic                   mclk, rst_b, psel, penable, pwrite, pready, pslverr, err;
	logic [`APC_ADDR_W-1:0] paddr;
	logic [31:0]            pwdata, prdata, rd;
	logic                   enc_a, enc_b, enc_up, enc_dn, dual, alm, sta_drv, stp_drv;
	logic                   step_a, step_b, trig, irq, stp_seen;
	logic [2:0]             pins;
	int                     fwd_cnt, rev_cnt, n_trig, n_errors, num_checks;

	apc_axis #(.PULSE(PULSE)) dut (.mclk(mclk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .encoder_phase_a(enc_a),
		.encoder_phase_b(enc_b), .encoder_index_in(1'b0), .position_capture_in(pins[0]),
		.axis_alarm_in(alm), .sync_start_line(sta_drv | pins[1]),
		.sync_stop_line(stp_drv | pins[2]), .sync_start_drive(sta_drv),
		.sync_stop_drive(stp_drv), .step_out_a(step_a), .step_out_b(step_b),
		.compare_trigger_out(trig), .irq(irq));
	apc_far_model u_far (.mclk(mclk), .rst_b(rst_b), .enc_up(enc_up), .enc_dn(enc_dn),
		.dual(dual), .step_out_a(step_a), .step_out_b(step_b), .encoder_phase_a(enc_a),
		.encoder_phase_b(enc_b), .fwd_cnt(fwd_cnt), .rev_cnt(rev_cnt));

	always @(posedge trig) n_trig++;
	always @(posedge stp_drv) stp_seen = 1'b1;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			n_errors++;
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one wait state: pready is sampled high at the second access edge
		chk("pready wait", 32'h2, 32'(n));
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask

	task automatic enc(input logic up, input int n);
		@(posedge mclk);
		enc_up <= up;
		enc_dn <= !up;
		repeat (n) @(posedge mclk);
		enc_up <= 1'b0;
		enc_dn <= 1'b0;
	endtask

	task automatic pls(input logic [2:0] m);
		@(posedge mclk);
		pins <= m;
		@(posedge mclk);
		pins <= 3'h0;
	endtask

	// bounded poll: a hung axis ends as a mismatch, not a stall
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			apb(1'b0, `APC_REG_STATUS, 32'h0);
			n++;
		end while (rd[`APC_ST_BUSY] !== 1'b0 && n < 200);
		chk("idle", 32'h0, {31'h0, rd[`APC_ST_BUSY]});
	endtask

	task automatic move(input logic d, input logic [27:0] n, input int ef, input int er);
		int f0, r0;
		f0 = fwd_cnt;
		r0 = rev_cnt;
		apb(1'b1, `APC_REG_MOVE, {d, 3'h0, n});
		apb(1'b1, `APC_REG_CMD, 32'h1);
		wait_idle();
		chk("fwd steps", 32'(ef), 32'(fwd_cnt - f0));
		chk("rev steps", 32'(er), 32'(rev_cnt - r0));
	endtask

	task automatic results;
		if (n_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	initial begin
		#(100 * 30000);
		chk("watchdog", 32'h0, 32'h1);
		results();
	end

	initial begin
		{rst_b, psel, penable, pwrite, enc_up, enc_dn, dual, alm, stp_seen} = 9'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pins = 3'h0;
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		rc(`APC_REG_CTRL, 32'h0, "ctrl reset");
		rc(`APC_REG_PERIOD, 32'h64, "period reset");
		rc(`APC_REG_INT_MASK, 32'h0, "mask reset");
		rc(8'hfc, 32'h0, "unmapped");
		chk("slverr", 32'h1, {31'h0, err});
		apb(1'b1, `APC_REG_INT_MASK, 32'h1f);
		enc(1'b1, 5);
		rc(`APC_REG_POSITION, 32'h5, "pos up");
		enc(1'b0, 7);
		rc(`APC_REG_POSITION, 32'hfffffffe, "pos down");
		apb(1'b1, `APC_REG_POSITION, 32'h7ffffff);
		enc(1'b1, 1);
		rc(`APC_REG_POSITION, 32'hf8000000, "pos wrap");
		// compare fifo: two queued values, then empty, then refilled
		apb(1'b1, `APC_REG_POSITION, 32'h0);
		apb(1'b1, `APC_REG_CMP, 32'h3);
		apb(1'b1, `APC_REG_CMP, 32'h5);
		enc(1'b1, 3);
		repeat (2 * PULSE) @(posedge mclk);
		chk("trig first", 32'h1, 32'(n_trig));
		enc(1'b1, 2);
		repeat (2 * PULSE) @(posedge mclk);
		chk("trig reload", 32'h2, 32'(n_trig));
		enc(1'b1, 2);
		repeat (2 * PULSE) @(posedge mclk);
		chk("trig empty", 32'h2, 32'(n_trig));
		apb(1'b1, `APC_REG_CMP, 32'h9);
		enc(1'b1, 2);
		repeat (2 * PULSE) @(posedge mclk);
		chk("trig refill", 32'h3, 32'(n_trig));
		// capture, then move on: the latch must keep the old count
		pls(3'h1);
		enc(1'b1, 3);
		rc(`APC_REG_LATCH, 32'h9, "latch");
		chk("irq set", 32'h1, {31'h0, irq});
		apb(1'b1, `APC_REG_INT_STATUS, 32'h1f);
		apb(1'b1, `APC_REG_INT_MASK, 32'h0);
		chk("irq clear", 32'h0, {31'h0, irq});
		pls(3'h1);
		rc(`APC_REG_INT_STATUS, 32'h2, "int latch");
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, `APC_REG_INT_STATUS, 32'h1f);
		apb(1'b1, `APC_REG_INT_MASK, 32'h1f);
		// step formats and backlash
		apb(1'b1, `APC_REG_PERIOD, 32'h4);
		apb(1'b1, `APC_REG_BACKLASH, 32'h3);
		move(1'b0, 28'h4, 4, 0);
		move(1'b1, 28'h2, 0, 5);
		apb(1'b1, `APC_REG_CTRL, 32'h2);
		move(1'b0, 28'h2, 2, 0);
		apb(1'b1, `APC_REG_CTRL, 32'h1);
		dual <= 1'b1;
		move(1'b1, 28'h3, 0, 6);
		// start and stop from the shared lines
		apb(1'b1, `APC_REG_CTRL, 32'h8);
		dual <= 1'b0;
		apb(1'b1, `APC_REG_MOVE, 32'd40);
		pls(3'h2);
		rc(`APC_REG_STATUS, 32'h9, "sync busy");
		pls(3'h4);
		apb(1'b0, `APC_REG_STATUS, 32'h0);
		chk("sync idle", 32'h0, {31'h0, rd[`APC_ST_BUSY]});
		// abnormal stop also drives the common stop
		apb(1'b1, `APC_REG_CTRL, 32'hc);
		stp_seen = 1'b0;
		apb(1'b1, `APC_REG_CMD, 32'h1);
		@(posedge mclk);
		alm <= 1'b1;
		repeat (12) @(posedge mclk);
		apb(1'b0, `APC_REG_STATUS, 32'h0);
		chk("abn idle", 32'h0, {31'h0, rd[`APC_ST_BUSY]});
		chk("abn sync", 32'h1, {31'h0, stp_seen});
		apb(1'b0, `APC_REG_INT_STATUS, 32'h0);
		chk("abn int", 32'h1, {31'h0, rd[`APC_INT_ABN]});
		alm <= 1'b0;
		// software start and stop of the same axis
		apb(1'b1, `APC_REG_CMD, 32'h1);
		apb(1'b0, `APC_REG_STATUS, 32'h0);
		chk("sw start", 32'h1, {31'h0, rd[`APC_ST_BUSY]});
		apb(1'b1, `APC_REG_CMD, 32'h2);
		apb(1'b0, `APC_REG_STATUS, 32'h0);
		chk("sw stop", 32'h0, {31'h0, rd[`APC_ST_BUSY]});
		results();
	end
endmodule
